/* shared/sync_hub_pkg.sv */
// Purpose: shared constants and carriers of the multi-board sync hub
// Assumes: axi4-lite register bus with 32-bit data, byte addresses
// Notes:   every offset, field position and reset value lives here
package sync_hub_pkg;

  localparam int ADDR_W = 16;
  localparam int NBOARD = 16;

  // register byte addresses
  localparam logic [15:0] OFS_PART_MASK  = 16'hc030;
  localparam logic [15:0] OFS_CLK_MASTER = 16'hc044;
  localparam logic [15:0] OFS_RUN_CMD    = 16'h0064;
  localparam logic [15:0] OFS_STATUS     = 16'h0068;
  localparam logic [15:0] OFS_DIV_REQ    = 16'h006c;

  // reset values
  localparam logic [15:0] PART_MASK_RST  = 16'h0000;
  localparam logic [15:0] CLK_MASTER_RST = 16'h0000;
  localparam logic [13:0] DIV_REQ_RST    = 14'h0002;
  localparam logic [12:0] DIV_EFF_RST    = 13'h0002;

  // divider limits, even steps only
  localparam logic [12:0] DIV_MIN = 13'h0002;
  localparam logic [12:0] DIV_MAX = 13'h1ffe;

  // run command bit positions, also the forwarding order
  localparam int CMD_FULL_RESET     = 0;
  localparam int CMD_WRITE_SETUP    = 1;
  localparam int CMD_START_RUN      = 2;
  localparam int CMD_ARM_TRIGGER    = 3;
  localparam int CMD_FORCE_TRIGGER  = 4;
  localparam int CMD_DISARM_TRIGGER = 5;
  localparam int CMD_STOP_RUN       = 6;
  localparam int CMD_BITS           = 7;

  // status register field positions
  localparam int ST_RUNNING  = 0;
  localparam int ST_ARMED    = 1;
  localparam int ST_CFG_ERR  = 2;
  localparam int ST_HUB_DONE = 3;
  localparam int ST_BUSY     = 4;
  localparam int ST_DIV_LSB  = 16;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'h0,
    SEQ_CHECK = 2'h1,
    SEQ_ISSUE = 2'h3
  } seq_state_t;

  // one command beat to the participating boards
  typedef struct packed {
    logic                valid;
    logic [CMD_BITS-1:0] code;
    logic [NBOARD-1:0]   targets;
  } board_cmd_t;

endpackage

/* hdl/slave_clock_divider.sv */
// Purpose: even divider of the distributed master clock
// Assumes: master_edge is a one-cycle pulse per master rising edge
// Notes:   output toggles every half master edges, idle low
module slave_clock_divider
  import sync_hub_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // control
  input  wire logic        run,
  input  wire logic        master_edge,
  input  wire logic [11:0] half,
  // divided clock
  output logic             div_clk
);

  typedef struct packed {
    logic [11:0] cnt;
    logic        clk;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;

  // count master edges, toggle at half the even divider
  always_comb
  begin
    next_st = st;
    if (!run)
    begin
      next_st.cnt = 12'h000;
      next_st.clk = 1'b0;
    end
    else if (master_edge)
    begin
      if (st.cnt + 12'h001 >= half)
      begin
        next_st.cnt = 12'h000;
        next_st.clk = ~st.clk;
      end
      else
      begin
        next_st.cnt = st.cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign div_clk = st.clk;

endmodule

/* hdl/sync_hub.sv */
// Purpose: hub joining several boards into one synchronized system
// Assumes: board pins are asynchronous to aclk, master clock << aclk
// Notes:   run commands are checked, then forwarded one per cycle
//
// Behaviour
// - participant mask chooses boards in synchronized run
// - mask bits follow logical connection index
// - index i is mask bit i, sixteen max
// - clock master mask has exactly one bit
// - master's clock distributed to all participants
// - slaves divide master by even divider <=8190
// - inexact divider rounds to nearest on start
// - any participant trigger triggers whole system
// - trigger delay ignored while synchronized
// - commands checked, then forwarded in order
// - write-only command, reset bit resets boards
// - write setup transfers config, no run
// - start writes changed settings then runs
// - configuration frozen while run active
// - arm trigger with start or later
// - force trigger fires immediately
// - disarm ignores triggers until re-armed
// - run starts with trigger disarmed
// - stop ends run, no effect if idle
// - wait completes on hub board state
module sync_hub
  import sync_hub_pkg::*;
#(
  parameter int          NB        = NBOARD,
  parameter logic [3:0]  HUB_INDEX = 4'h0
)
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address and data
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // axi4-lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // board pins, asynchronous
  input  wire logic [NB-1:0]     board_clk,
  input  wire logic [NB-1:0]     board_trig,
  input  wire logic [NB-1:0]     board_done,
  // towards the boards
  output logic [NB-1:0]          board_member,
  output logic                   sys_clk,
  output logic                   slave_clk,
  output logic                   sys_trigger,
  output logic                   trig_delay_bypass,
  output board_cmd_t             board_cmd
);

  typedef struct packed {
    // bus side
    logic                aw_held;
    logic [ADDR_W-1:0]   aw_addr;
    logic                w_held;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
    // configuration
    logic [NB-1:0]       part_mask;
    logic [NB-1:0]       clk_mask;
    logic [13:0]         div_req;
    logic [12:0]         div_eff;
    logic                dirty;
    // run control
    seq_state_t          seq;
    logic [2:0]          step;
    logic [CMD_BITS-1:0] pend;
    logic                running;
    logic                armed;
    logic                cfg_err;
    logic                force_fire;
    // pin synchronisers
    logic [NB-1:0]       clk_s1;
    logic [NB-1:0]       clk_s2;
    logic [NB-1:0]       trig_s1;
    logic [NB-1:0]       trig_s2;
    logic [NB-1:0]       done_s1;
    logic [NB-1:0]       done_s2;
    logic                mclk_prev;
    // outputs
    logic                sys_clk;
    logic                sys_trigger;
    board_cmd_t          cmd;
  } hub_state_t;

  hub_state_t st;
  hub_state_t next_st;
  logic       master_edge;

  // merge a write under byte enables
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    return r;
  endfunction

  // exactly one bit set
  function automatic logic one_hot(input logic [NB-1:0] v);
    return (v != '0) && ((v & (v - 1'b1)) == '0);
  endfunction

  // nearest even divider within the permitted range
  function automatic logic [12:0] even_div(input logic [13:0] req);
    logic [14:0] up;
    up = {1'b0, req} + 15'h0001;
    up[0] = 1'b0;
    if (up < {2'h0, DIV_MIN})
      return DIV_MIN;
    else if (up > {2'h0, DIV_MAX})
      return DIV_MAX;
    else
      return up[12:0];
  endfunction

  always_comb
  begin
    logic [31:0] wv;
    logic        do_write;
    logic        locked;
    wv       = '0;
    do_write = 1'b0;
    locked   = 1'b0;
    next_st  = st;
    next_st.force_fire = 1'b0;
    next_st.cmd.valid  = 1'b0;

    // two-stage synchronisers on every board pin
    next_st.clk_s1  = board_clk;
    next_st.clk_s2  = st.clk_s1;
    next_st.trig_s1 = board_trig;
    next_st.trig_s2 = st.trig_s1;
    next_st.done_s1 = board_done;
    next_st.done_s2 = st.done_s1;

    // selected master clock goes out to every board
    next_st.sys_clk   = |(st.clk_s2 & st.clk_mask);
    next_st.mclk_prev = st.sys_clk;

    // run ends once every participant reports done
    if (st.running && st.part_mask != '0 &&
        (st.done_s2 & st.part_mask) == st.part_mask)
    begin
      next_st.running = 1'b0;
      next_st.armed   = 1'b0;
    end

    // write channels are taken independently
    if (awvalid && !st.aw_held)
    begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (wvalid && !st.w_held)
    begin
      next_st.w_held = 1'b1;
      next_st.w_data = wdata;
      next_st.w_strb = wstrb;
    end
    if (bvalid && bready)
      next_st.bvalid = 1'b0;

    // register write once address and data are both held
    if (st.aw_held && st.w_held && !st.bvalid)
    begin
      do_write        = 1'b1;
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = RESP_OKAY;
      locked          = st.running;
      case (st.aw_addr)
        OFS_PART_MASK:
        begin
          wv = merge_bytes({16'h0000, st.part_mask}, st.w_data,
                           st.w_strb);
          if (locked)
            next_st.bresp = RESP_SLVERR;
          else
          begin
            next_st.part_mask = wv[NB-1:0];
            next_st.dirty     = 1'b1;
          end
        end
        OFS_CLK_MASTER:
        begin
          wv = merge_bytes({16'h0000, st.clk_mask}, st.w_data,
                           st.w_strb);
          if (locked)
            next_st.bresp = RESP_SLVERR;
          else
          begin
            next_st.clk_mask = wv[NB-1:0];
            next_st.dirty    = 1'b1;
          end
        end
        OFS_DIV_REQ:
        begin
          wv = merge_bytes({18'h00000, st.div_req}, st.w_data,
                           st.w_strb);
          if (locked)
            next_st.bresp = RESP_SLVERR;
          else
          begin
            next_st.div_req = wv[13:0];
            next_st.dirty   = 1'b1;
          end
        end
        OFS_RUN_CMD:
        begin
          // a second command while one is in flight is refused
          if (st.seq != SEQ_IDLE)
            next_st.bresp = RESP_SLVERR;
          else if (st.w_data[CMD_BITS-1:0] != '0)
          begin
            next_st.pend = st.w_data[CMD_BITS-1:0];
            next_st.seq  = SEQ_CHECK;
          end
        end
        OFS_STATUS:
          next_st.bresp = RESP_SLVERR;
        default:
          next_st.bresp = RESP_DECERR;
      endcase
    end

    // reads answer one cycle after the address is taken
    if (rvalid && rready)
      next_st.rvalid = 1'b0;
    if (arvalid && !st.rvalid)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = RESP_OKAY;
      next_st.rdata  = 32'h0000_0000;
      case (araddr)
        OFS_PART_MASK:
          next_st.rdata = {16'h0000, st.part_mask};
        OFS_CLK_MASTER:
          next_st.rdata = {16'h0000, st.clk_mask};
        OFS_DIV_REQ:
          next_st.rdata = {18'h00000, st.div_req};
        OFS_STATUS:
        begin
          next_st.rdata[ST_RUNNING]  = st.running;
          next_st.rdata[ST_ARMED]    = st.armed;
          next_st.rdata[ST_CFG_ERR]  = st.cfg_err;
          next_st.rdata[ST_HUB_DONE] = st.done_s2[HUB_INDEX];
          next_st.rdata[ST_BUSY]     = st.seq != SEQ_IDLE;
          next_st.rdata[ST_DIV_LSB +: 13] = st.div_eff;
        end
        OFS_RUN_CMD:
          next_st.rresp = RESP_SLVERR; // write-only
        default:
          next_st.rresp = RESP_DECERR;
      endcase
    end

    // command sequencer: check, then one command per cycle
    case (st.seq)
      SEQ_IDLE:
        next_st.step = 3'h0;
      SEQ_CHECK:
      begin
        next_st.seq  = SEQ_ISSUE;
        next_st.step = 3'h0;
        if (st.pend[CMD_START_RUN])
        begin
          if (!one_hot(st.clk_mask) ||
              (st.clk_mask & st.part_mask) == '0)
          begin
            next_st.cfg_err = 1'b1;
            next_st.pend[CMD_START_RUN]     = 1'b0;
            next_st.pend[CMD_ARM_TRIGGER]   = 1'b0;
            next_st.pend[CMD_FORCE_TRIGGER] = 1'b0;
          end
          else
          begin
            next_st.cfg_err = 1'b0;
            if (st.dirty)
              next_st.pend[CMD_WRITE_SETUP] = 1'b1;
          end
        end
      end
      SEQ_ISSUE:
      begin
        next_st.step = st.step + 3'h1;
        if (st.step == 3'(CMD_STOP_RUN))
          next_st.seq = SEQ_IDLE;
        if (st.pend[st.step])
        begin
          // forwarding order follows the bit order
          next_st.cmd.valid   = 1'b1;
          next_st.cmd.code    = '0;
          next_st.cmd.code[st.step] = 1'b1;
          next_st.cmd.targets = st.part_mask;
          case (int'(st.step))
            CMD_FULL_RESET:
            begin
              next_st.running = 1'b0;
              next_st.armed   = 1'b0;
              next_st.dirty   = 1'b1;
            end
            CMD_WRITE_SETUP:
            begin
              next_st.div_eff = even_div(st.div_req);
              next_st.dirty   = 1'b0;
            end
            CMD_START_RUN:
            begin
              next_st.running = 1'b1;
              next_st.armed   = 1'b0;
            end
            CMD_ARM_TRIGGER:
              next_st.armed = st.running ||
                              st.pend[CMD_START_RUN];
            CMD_FORCE_TRIGGER:
              next_st.force_fire = 1'b1;
            CMD_DISARM_TRIGGER:
              next_st.armed = 1'b0;
            CMD_STOP_RUN:
            begin
              // stop on an idle hub is swallowed
              next_st.cmd.valid = st.running;
              next_st.running   = 1'b0;
              next_st.armed     = 1'b0;
            end
            default:
              next_st.cmd.valid = 1'b0;
          endcase
        end
      end
      default:
        next_st.seq = SEQ_IDLE;
    endcase

    // any participant's trigger fires the whole system
    next_st.sys_trigger = st.force_fire ||
      (st.running && st.armed &&
       |(st.trig_s2 & st.part_mask));
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st           <= '0;
      st.seq       <= SEQ_IDLE;
      st.part_mask <= PART_MASK_RST;
      st.clk_mask  <= CLK_MASTER_RST;
      st.div_req   <= DIV_REQ_RST;
      st.div_eff   <= DIV_EFF_RST;
      st.dirty     <= 1'b1;
    end
    else
      st <= next_st;
  end

  // master rising edge seen through the synchroniser
  assign master_edge = st.sys_clk && !st.mclk_prev;

  slave_clock_divider u_div (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .run         (st.running),
    .master_edge (master_edge),
    .half        (st.div_eff[12:1]),
    .div_clk     (slave_clk)
  );

  // handshake outputs and data are all driven from flops, readies inverted
  assign awready           = !st.aw_held;
  assign wready            = !st.w_held;
  assign bvalid            = st.bvalid;
  assign bresp             = st.bresp;
  assign arready           = !st.rvalid;
  assign rvalid            = st.rvalid;
  assign rresp             = st.rresp;
  assign rdata             = st.rdata;
  assign board_member      = st.part_mask;
  assign sys_clk           = st.sys_clk;
  assign sys_trigger       = st.sys_trigger;
  assign trig_delay_bypass = st.running;
  assign board_cmd         = st.cmd;

endmodule

/* sim/board_model.sv */
// Purpose: behavioural boards on the far side of the hub
// Assumes: board clocks free running, master board fastest
// Notes:   done pins only report a request while a board is running
module board_model
  import sync_hub_pkg::*;
#(
  parameter int MASTER = 2
)
(
  // clock
  input  wire logic              aclk,
  // commands towards the boards
  input  wire board_cmd_t        board_cmd,
  // bench requests
  input  wire logic [NBOARD-1:0] trig_req,
  input  wire logic [NBOARD-1:0] done_req,
  // board pins
  output logic [NBOARD-1:0]      board_clk,
  output logic [NBOARD-1:0]      board_trig,
  output logic [NBOARD-1:0]      board_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fast = '0;
  logic slow = '0;
  logic run  = '0;

  // odd start offset keeps the fast clock off the aclk grid
  initial
  begin
    #7;
    forever #100 fast = ~fast;
  end
  always #200 slow = ~slow;

  // only the master board carries the fast clock
  always_comb
  begin
    board_clk         = {NBOARD{slow}};
    board_clk[MASTER] = fast;
  end

  // a board runs from its start beat until stop or reset
  always @(posedge aclk)
    if (board_cmd.valid)
    begin
      if (board_cmd.code[CMD_START_RUN])
        run <= '1;
      if (board_cmd.code[CMD_STOP_RUN] | board_cmd.code[CMD_FULL_RESET])
        run <= '0;
    end

  assign board_trig = trig_req;
  // an idle board must not look finished, or a fresh run ends at once
  assign board_done = done_req & {NBOARD{run}};
endmodule

/* sim/sync_hub_checker.sv */
// Purpose: port-level checks of the sync hub
// Assumes: single aclk domain, synchronous low reset
// Notes:   bound into every sync_hub instance
module sync_hub_checker
  import sync_hub_pkg::*;
#(
  parameter int NB = NBOARD
)
(
  // clock and reset
  input wire logic          aclk,
  input wire logic          aresetn,
  // write data channel
  input wire logic          wvalid,
  input wire logic          wready,
  // board side
  input wire logic [NB-1:0] board_member,
  input wire logic          slave_clk,
  input wire logic          sys_trigger,
  input wire logic          trig_delay_bypass,
  input wire board_cmd_t    board_cmd
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // helper nets, no sampled functions here
  wire logic                wtake = wvalid & wready;
  wire logic                fbeat = board_cmd.valid
                                  & board_cmd.code[CMD_FORCE_TRIGGER];
  wire logic [CMD_BITS-1:0] code  = board_cmd.code;
  wire logic                run   = trig_delay_bypass;

  sequence s_beat;
    board_cmd.valid;
  endsequence
  sequence s_two_beats;
    s_beat ##1 s_beat;
  endsequence

  property p_member;
    $changed(board_member) |->
      $past(wtake) || $past(wtake, 2) || $past(wtake, 3);
  endproperty
  property p_bypass;
    $rose(slave_clk) |-> $past(run);
  endproperty
  property p_slave_idle;
    (!run) [*3] |-> !slave_clk;
  endproperty
  property p_beat;
    s_beat |-> $onehot(code) && board_cmd.targets == board_member;
  endproperty
  property p_order;
    s_two_beats |-> code > $past(code);
  endproperty
  property p_force;
    fbeat |-> ##[1:2] sys_trigger;
  endproperty
  // stop may land the edge the run flag drops, so look back one
  property p_trig_run;
    sys_trigger |-> run || $past(run) || $past(fbeat) || $past(fbeat, 2);
  endproperty
  property p_stop;
    s_beat ##0 code[CMD_STOP_RUN] |-> run || $past(run);
  endproperty

  a_member: assert property (p_member)
    else $error("board member changed without a write");
  a_bypass: assert property (p_bypass)
    else $error("slave clock runs without delay bypass");
  a_slave_idle: assert property (p_slave_idle)
    else $error("slave clock high while idle");
  a_beat: assert property (p_beat)
    else $error("command beat not one-hot or wrong targets");
  a_order: assert property (p_order)
    else $error("command beats out of order");
  a_force: assert property (p_force)
    else $error("force beat gave no trigger");
  a_trig_run: assert property (p_trig_run)
    else $error("system trigger outside a run");
  a_stop: assert property (p_stop)
    else $error("stop forwarded while idle");
endmodule

bind sync_hub sync_hub_checker #(.NB(NB)) u_sync_hub_checker
(
  .aclk,
  .aresetn,
  .wvalid,
  .wready,
  .board_member,
  .slave_clk,
  .sys_trigger,
  .trig_delay_bypass,
  .board_cmd
);

/* sim/testbench.sv */
// Purpose: self-checking bench of the sync hub
// Assumes: boards model on the far side, one bus master
// Notes:   commands wait the fixed sequencer span
module testbench
  import sync_hub_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("mismatch at %0t got %h exp %h", $time, g, e); \
    end \
  end
  logic             aclk = '0, aresetn = '0;
  logic [15:0]      awaddr = '0, araddr = '0;
  logic             awvalid = '0, wvalid = '0, bready = '0;
  logic             arvalid = '0, rready = '0;
  logic [31:0]      wdata = '0, rdv;
  logic [3:0]       wstrb = 4'hf;
  logic             awready, wready, bvalid, arready, rvalid;
  logic [1:0]       bresp, rresp, rs;
  logic [31:0]      rdata;
  logic [15:0]      board_member, board_clk, board_trig, board_done;
  logic [15:0]      trig_req = '0, done_req = '0;
  logic             slave_clk, sys_trigger, trig_delay_bypass, sd;
  logic             sys_clk, mc;
  board_cmd_t       board_cmd;
  int               error_cnt = 0, tests_run = 0, n;
  int               trig_cnt = 0, beat_cnt = 0, sclk_cnt = 0;
  int               mclk_cnt = 0, m;
  logic [31:0]      dreq[2] = '{32'h3fff, 32'h0005};
  logic [31:0]      dexp[2] = '{32'h1ffe0000, 32'h00060000};
  logic [31:0]      bad[2]  = '{32'h0006, 32'h0010};

  sync_hub u_sync_hub (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .board_clk,
    .board_trig, .board_done, .board_member, .sys_clk, .slave_clk,
    .sys_trigger, .trig_delay_bypass, .board_cmd);
  board_model u_board_model (.aclk, .board_cmd, .trig_req, .done_req,
    .board_clk, .board_trig, .board_done);

  initial forever #12.5 aclk = ~aclk;

  // event counters seen at each edge
  always @(posedge aclk)
  begin
    sd <= slave_clk;
    trig_cnt <= trig_cnt + sys_trigger;
    beat_cnt <= beat_cnt + board_cmd.valid;
    sclk_cnt <= sclk_cnt + (slave_clk & ~sd);
    mc <= sys_clk;
    mclk_cnt <= mclk_cnt + (sys_clk & ~mc);
  end

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // readies sampled mid-cycle, so they equal what the edge sees
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw, tb, pb;
    pb = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= '1;
    wvalid <= '1;
    bready <= '1;
    for (int i = 0; i < 60 && pb; i++)
    begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      tb = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ta)
        awvalid <= '0;
      if (tw)
        wvalid <= '0;
      if (tb)
      begin
        bready <= '0;
        pb = 1'b0;
      end
    end
    `CHK(pb, 1'b0)
    `CHK(rs, er)
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] m, e,
                    input logic [1:0] er);
    logic ta, tr, pr;
    pr = 1'b1;
    @(posedge aclk);
    araddr <= a;
    arvalid <= '1;
    rready <= '1;
    for (int i = 0; i < 60 && pr; i++)
    begin
      @(negedge aclk);
      ta = arready;
      tr = rvalid;
      rs = rresp;
      rdv = rdata;
      @(posedge aclk);
      if (ta)
        arvalid <= '0;
      if (tr)
      begin
        rready <= '0;
        pr = 1'b0;
      end
    end
    `CHK(rs, er)
    `CHK(pr, 1'b0)
    `CHK(rdv & m, e)
  endtask

  // sequencer is done well inside this fixed span
  task automatic cmd(input logic [31:0] c);
    wr(OFS_RUN_CMD, c, RESP_OKAY);
    repeat (12) @(posedge aclk);
  endtask

  task automatic pulse(input logic [15:0] p, input logic e);
    int k;
    k = trig_cnt;
    @(posedge aclk);
    trig_req <= p;
    repeat (12) @(posedge aclk);
    trig_req <= '0;
    repeat (12) @(posedge aclk);
    `CHK(trig_cnt != k, e)
  endtask

  initial
  begin
    #150000;
    error_cnt++;
    print_verdict();
  end

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= '1;
    rd(OFS_PART_MASK, 32'hffff, 32'h0, RESP_OKAY);
    rd(OFS_CLK_MASTER, 32'hffff, 32'h0, RESP_OKAY);
    rd(OFS_STATUS, 32'h1fff0007, 32'h00020000, RESP_OKAY);
    rd(OFS_RUN_CMD, 32'h0, 32'h0, RESP_SLVERR);
    rd(16'h0100, 32'h0, 32'h0, RESP_DECERR);
    $display("test reset values done");
    wr(OFS_PART_MASK, 32'h8001, RESP_OKAY);
    `CHK(board_member, 16'h8001)
    wr(OFS_PART_MASK, 32'h000f, RESP_OKAY);
    rd(OFS_PART_MASK, 32'hffff, 32'h000f, RESP_OKAY);
    $display("test participant mask done");
    foreach (bad[i])
    begin
      wr(OFS_CLK_MASTER, bad[i], RESP_OKAY);
      cmd(32'h4);
      rd(OFS_STATUS, 32'h7, 32'h4, RESP_OKAY);
    end
    $display("test bad clock master done");
    foreach (dreq[i])
    begin
      wr(OFS_DIV_REQ, dreq[i], RESP_OKAY);
      cmd(32'h2);
      rd(OFS_STATUS, 32'h1fff0001, dexp[i], RESP_OKAY);
    end
    $display("test divider done");
    wr(OFS_CLK_MASTER, 32'h0004, RESP_OKAY);
    n = beat_cnt;
    cmd(32'h4);
    `CHK(beat_cnt - n, 2)
    rd(OFS_STATUS, 32'h3, 32'h1, RESP_OKAY);
    `CHK(trig_delay_bypass, 1'b1)
    wr(OFS_PART_MASK, 32'h0003, RESP_SLVERR);
    pulse(16'h0002, 1'b0);
    cmd(32'h8);
    pulse(16'h0020, 1'b0);
    pulse(16'h0002, 1'b1);
    cmd(32'h20);
    pulse(16'h0001, 1'b0);
    n = trig_cnt;
    cmd(32'h10);
    `CHK(trig_cnt != n, 1'b1)
    n = sclk_cnt;
    m = mclk_cnt;
    repeat (200) @(posedge aclk);
    `CHK((sclk_cnt - n) inside {[4:5]}, 1'b1)
    `CHK((mclk_cnt - m) inside {[24:26]}, 1'b1)
    $display("test run and trigger done");
    done_req <= 16'h0001;
    repeat (8) @(posedge aclk);
    rd(OFS_STATUS, 32'h9, 32'h9, RESP_OKAY);
    cmd(32'h40);
    rd(OFS_STATUS, 32'h1, 32'h0, RESP_OKAY);
    n = beat_cnt;
    cmd(32'h40);
    `CHK(beat_cnt == n, 1'b1)
    done_req <= '0;
    n = beat_cnt;
    cmd(32'h4);
    `CHK(beat_cnt - n, 1)
    cmd(32'h1);
    rd(OFS_STATUS, 32'h3, 32'h0, RESP_OKAY);
    rd(OFS_PART_MASK, 32'hffff, 32'h000f, RESP_OKAY);
    $display("test stop and reset done");
    print_verdict();
  end
endmodule
